// file: common/dcffs_defines.vh
// constants for the flag-synchronised nine-bit fifo block
// assumes one 100 MHz clock and an avalon-mm master with waitrequest
// Contract
// (R1) full flag clears one write edge after read; the code clears it on the third edge after the read edge
// (R2) empty flag clears after write crosses over
// (R3) clocks may run freely while reset held
// (R4) data outputs low after reset, enable-gated
// (R5) second pin high at reset: write enable
// (R6) second pin low at reset: offset load
// (R7) first word reaches reader in bounded cycles
// (R8) first word readable after empty clears
// (R9) empty flag made in reader domain
// (R10) full flag made in writer domain
// (R11) reset empties fifo; reset before use
// (R12) pointers cross as gray through two flops
`ifndef DCFFS_DEFINES_VH
`define DCFFS_DEFINES_VH

`define DCFFS_WIDTH 9
`define DCFFS_DEPTH 8
`define DCFFS_AW 3

`define DCFFS_CLK_NS 10
`define DCFFS_FULL_SKEW_NS 5
`define DCFFS_EMPTY_SKEW_NS 10
`define DCFFS_FULL_SKEW_CYC \
  ((`DCFFS_FULL_SKEW_NS + `DCFFS_CLK_NS - 1) / `DCFFS_CLK_NS)
`define DCFFS_EMPTY_SKEW_CYC \
  ((`DCFFS_EMPTY_SKEW_NS + `DCFFS_CLK_NS - 1) / `DCFFS_CLK_NS)

`define DCFFS_ADDR_W 4
`define DCFFS_DATA_W 32
`define DCFFS_CTRL_ADDR 4'h0
`define DCFFS_STATUS_ADDR 4'h4
`define DCFFS_OFFSET_ADDR 4'h8

`define DCFFS_CTRL_W 2
`define DCFFS_CTRL_RST 2'h0
`define DCFFS_CTRL_WINH 0
`define DCFFS_CTRL_RINH 1

`define DCFFS_ST_EMPTY_N 0
`define DCFFS_ST_FULL_N 1
`define DCFFS_ST_TWO_EN 2
`define DCFFS_ST_PENDING 3

`define DCFFS_OFS_COUNT 4
`define DCFFS_OFS_SEL_W 2
`define DCFFS_OFS_W 8
`define DCFFS_OFS_RST 8'h07
`define DCFFS_SEL_RST 2'h0

`endif

// file: sim/dcffs_reader.sv
// reader beside the fifo: read enable with stall, collects words
// assumes valid and data registered on the same clock
`timescale 1ns/100ps
`default_nettype none
module dcffs_reader (
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic valid_i,
  input wire logic [8:0] data_i,
  output logic rd_en_n_o
);
  logic [8:0] got[$];
  initial rd_en_n_o = 1'b1;
  always @(posedge clk_i) begin
    rd_en_n_o <= stall_i;
    if (valid_i === 1'b1) begin
      got.push_back(data_i);
    end
  end
endmodule
`default_nettype wire

// file: sim/dcffs_top_assertions.sv
// checker: flag, data and enable timing at the fifo top ports
// assumes one clock domain; bound from the bench top
`timescale 1ns/100ps
`default_nettype none
module dcffs_top_chk (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic WR_EN_N_I,
  input wire logic RD_EN_N_I,
  input wire logic OUT_ENABLE_N_I,
  input wire logic FULL_FLAG_N_O,
  input wire logic EMPTY_FLAG_N_O,
  input wire logic [8:0] RD_DATA_O,
  input wire logic RD_DATA_OE_N_O,
  input wire logic RD_VALID_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  oe_copy_a: assert property (
    $past(RST_B_I) |-> RD_DATA_OE_N_O == $past(OUT_ENABLE_N_I))
    else $error("enable copy wrong");
  reset_state_a: assert property (
    $rose(RST_B_I) |-> !EMPTY_FLAG_N_O && FULL_FLAG_N_O
      && RD_DATA_O == 9'h000)
    else $error("state after reset wrong");
  data_hold_a: assert property (
    !RD_VALID_O |-> $stable(RD_DATA_O))
    else $error("data moved without valid");
  // flag is one flop behind the write that filled the last slot
  full_cause_a: assert property (
    $fell(FULL_FLAG_N_O) |-> !$past(WR_EN_N_I, 2))
    else $error("full without write");
  // sync latency fixed at three edges; window kept loose by one edge before and two after
  empty_cause_a: assert property (
    $rose(EMPTY_FLAG_N_O) |-> !($past(WR_EN_N_I, 2) && $past(WR_EN_N_I, 3)
      && $past(WR_EN_N_I, 4) && $past(WR_EN_N_I, 5)))
    else $error("empty cleared without write");
  full_clear_a: assert property (
    $rose(FULL_FLAG_N_O) |-> !($past(RD_EN_N_I, 2) && $past(RD_EN_N_I, 3)
      && $past(RD_EN_N_I, 4) && $past(RD_EN_N_I, 5)))
    else $error("full cleared without read");
  first_word_a: assert property (
    $rose(EMPTY_FLAG_N_O) && !RD_EN_N_I |=> RD_VALID_O)
    else $error("first word late");
  flags_excl_a: assert property (
    EMPTY_FLAG_N_O || FULL_FLAG_N_O)
    else $error("empty and full together");
  cover property ($fell(FULL_FLAG_N_O));
  cover property ($rose(FULL_FLAG_N_O));
  cover property ($rose(EMPTY_FLAG_N_O) && !RD_EN_N_I);
endmodule
`default_nettype wire

// file: sim/test_dual_clock_fifo_flag_sync.sv
// bench for the nine-bit fifo: pins, strap modes and avalon registers
// assumes the reader model and the checker compiled before
`timescale 1ns/100ps
`default_nettype none
`include "dcffs_defines.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  err_total++; $display("FAIL %0t got %h exp %h", $time, a, b); end end
module test_dual_clock_fifo_flag_sync;
  logic clk = 0, rst_b = 0, wr_en_n = 1, sec = 1, oe_n = 0, stall = 1;
  logic avs_rd = 0, avs_wr = 0;
  logic [8:0] wr_data = 0;
  logic [3:0] avs_addr = 0;
  logic [31:0] avs_wdata = 0, q;
  wire full_n, empty_n, rd_valid, oe_out_n, wait_req, rd_en_n;
  wire [8:0] rd_data;
  wire [31:0] avs_rdata;
  int err_total = 0, check_count = 0, cyc_n = 0, n;
  dcffs_top i_dut (.CLK_I(clk), .RST_B_I(rst_b), .WR_DATA_I(wr_data),
    .WR_EN_N_I(wr_en_n), .SECOND_WRITE_ENABLE_OR_LOAD_I(sec),
    .FULL_FLAG_N_O(full_n), .RD_EN_N_I(rd_en_n), .OUT_ENABLE_N_I(oe_n),
    .RD_DATA_O(rd_data), .RD_DATA_OE_N_O(oe_out_n), .RD_VALID_O(rd_valid),
    .EMPTY_FLAG_N_O(empty_n), .AVS_ADDRESS_I(avs_addr),
    .AVS_READ_I(avs_rd), .AVS_WRITE_I(avs_wr), .AVS_WRITEDATA_I(avs_wdata),
    .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(avs_rdata),
    .AVS_WAITREQUEST_O(wait_req));
  dcffs_reader i_rdr (.clk_i(clk), .stall_i(stall), .valid_i(rd_valid),
    .data_i(rd_data), .rd_en_n_o(rd_en_n));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      err_total++;
      give_verdict;
    end
  end
  task give_verdict;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // clocks keep running through reset on purpose
  task do_reset(input logic strap);
    @(posedge clk);
    rst_b <= 0;
    sec <= strap;
    repeat (16) @(posedge clk);
    rst_b <= 1;
    repeat (2) @(posedge clk);
  endtask
  task avs(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_wr <= w;
    avs_rd <= !w;
    avs_addr <= a;
    avs_wdata <= d;
    // no cycle count assumed: only the bench timeout ends this wait
    do @(posedge clk); while (wait_req !== 1'b0);
    q = avs_rdata;
    avs_wr <= 0;
    avs_rd <= 0;
  endtask
  task wr_one(input logic [8:0] d);
    @(posedge clk);
    wr_en_n <= 0;
    wr_data <= d;
    @(posedge clk);
    wr_en_n <= 1;
  endtask
  task t_reset;
    `CHK({empty_n, full_n, rd_data}, {2'b01, 9'h000})
    `CHK(oe_out_n, 1'b0)
    oe_n <= 1;
    repeat (2) @(posedge clk);
    `CHK(oe_out_n, 1'b1)
    oe_n <= 0;
  endtask
  // reader already polling an empty fifo: refused reads, then first word
  task t_first;
    stall <= 0;
    repeat (3) @(posedge clk);
    wr_one(9'h1A5);
    n = 0;
    while (empty_n !== 1'b1 && n < 8) begin @(posedge clk); n++; end
    `CHK(n >= 3 && n <= 4, 1'b1)
    repeat (10) @(posedge clk);
    `CHK(i_rdr.got.size(), 1)
    `CHK(i_rdr.got[0], 9'h1A5)
  endtask
  task t_fill;
    stall <= 1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      wr_en_n <= 0;
      wr_data <= 9'h100 + 9'(i);
    end
    @(posedge clk);
    wr_en_n <= 1;
    @(posedge clk);
    `CHK(full_n, 1'b0)
    stall <= 0;
    n = 0;
    do begin @(posedge clk); n++; end while (full_n !== 1'b1 && n < 10);
    `CHK(n >= 5 && n <= 6, 1'b1)
    repeat (20) @(posedge clk);
    `CHK(i_rdr.got.size(), 9)
    for (int i = 0; i < 8; i++) begin
      `CHK(i_rdr.got[i+1], 9'h100 + 9'(i))
    end
  endtask
  // write inhibit drops words; read inhibit holds them until cleared
  task t_regs;
    avs(0, `DCFFS_STATUS_ADDR, 0);
    `CHK(q[3:0], 4'b0110)
    avs(1, `DCFFS_CTRL_ADDR, 32'h0000_0001);
    avs(0, `DCFFS_CTRL_ADDR, 0);
    `CHK(q, 32'h0000_0001)
    wr_one(9'h033);
    repeat (8) @(posedge clk);
    `CHK(empty_n, 1'b0)
    stall <= 1;
    avs(1, `DCFFS_CTRL_ADDR, 32'h0000_0002);
    wr_one(9'h0C3);
    repeat (6) @(posedge clk);
    stall <= 0;
    repeat (8) @(posedge clk);
    `CHK({empty_n, i_rdr.got.size() == 9}, 2'b11)
    avs(1, `DCFFS_CTRL_ADDR, 32'h0000_0000);
    repeat (6) @(posedge clk);
    `CHK(i_rdr.got.size(), 10)
    `CHK(i_rdr.got[9], 9'h0C3)
    avs(0, 4'hC, 0);
    `CHK(q, 32'h0000_0000)
  endtask
  // reset with a word held must empty the fifo, then load mode
  task t_load;
    stall <= 1;
    wr_one(9'h0F0);
    repeat (6) @(posedge clk);
    `CHK(empty_n, 1'b1)
    do_reset(0);
    `CHK(empty_n, 1'b0)
    wr_one(9'h05A);
    repeat (6) @(posedge clk);
    `CHK(empty_n, 1'b0)
    stall <= 0;
    @(posedge clk);
    stall <= 1;
    repeat (4) @(posedge clk);
    `CHK(i_rdr.got.size(), 11)
    `CHK(i_rdr.got[10], 9'h05A)
    avs(0, `DCFFS_OFFSET_ADDR, 0);
    `CHK(q[31:8], {3{`DCFFS_OFS_RST}})
    `CHK(q[7:0], 8'h5A)
    avs(0, `DCFFS_STATUS_ADDR, 0);
    `CHK(q[3:0], 4'b0010)
  endtask
  initial begin
    do_reset(1);
    t_reset;
    t_first;
    t_fill;
    t_regs;
    t_load;
    give_verdict;
  end
endmodule
bind dcffs_top dcffs_top_chk i_chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
  .WR_EN_N_I(WR_EN_N_I), .RD_EN_N_I(RD_EN_N_I),
  .OUT_ENABLE_N_I(OUT_ENABLE_N_I), .FULL_FLAG_N_O(FULL_FLAG_N_O),
  .EMPTY_FLAG_N_O(EMPTY_FLAG_N_O), .RD_DATA_O(RD_DATA_O),
  .RD_DATA_OE_N_O(RD_DATA_OE_N_O), .RD_VALID_O(RD_VALID_O));
`default_nettype wire

// file: src/dcffs_fifo.v
// gray-pointer fifo with two-flop pointer crossings
// assumes one clock; both pointer paths still cross through synchronisers
`timescale 1ns/100ps
`default_nettype none
module dcffs_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  output wire full_o,
  output wire empty_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wbin_reg;
  reg [AW:0] wgray_reg;
  reg [AW:0] rbin_reg;
  reg [AW:0] rgray_reg;
  reg [AW:0] rgray_s1_reg;
  reg [AW:0] rgray_s2_reg;
  reg [AW:0] wgray_s1_reg;
  reg [AW:0] wgray_s2_reg;
  wire [AW:0] wbin_next;
  wire [AW:0] rbin_next;
  wire push;
  wire pop;

  // full seen on the writer side against the synced reader pointer
  assign full_o = (wgray_reg ==
    {~rgray_s2_reg[AW:AW-1], rgray_s2_reg[AW-2:0]}); // see (R10)
  // empty seen on the reader side against the synced writer pointer
  assign empty_o = (rgray_reg == wgray_s2_reg); // see (R9)
  assign in_ready_o = ~full_o;
  assign out_valid_o = ~empty_o;
  // head word shown before the pop, so it is ready once empty clears
  assign out_data_o = mem[rbin_reg[AW-1:0]]; // see (R8)
  assign push = in_valid_i & ~full_o;
  assign pop = out_ready_i & ~empty_o;
  assign wbin_next = wbin_reg + {{AW{1'b0}}, 1'b1};
  assign rbin_next = rbin_reg + {{AW{1'b0}}, 1'b1};

  always @(posedge clk_i) begin
    if (push) begin
      mem[wbin_reg[AW-1:0]] <= in_data_i;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wbin_reg <= {(AW+1){1'b0}}; // see (R11)
      wgray_reg <= {(AW+1){1'b0}};
      rbin_reg <= {(AW+1){1'b0}};
      rgray_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wbin_reg <= wbin_next;
        wgray_reg <= wbin_next ^ (wbin_next >> 1); // see (R12)
      end
      if (pop) begin
        rbin_reg <= rbin_next;
        rgray_reg <= rbin_next ^ (rbin_next >> 1); // see (R12)
      end
    end
  end

  // two stages each way; this is the fixed two-cycle flag slack
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rgray_s1_reg <= {(AW+1){1'b0}};
      rgray_s2_reg <= {(AW+1){1'b0}};
      wgray_s1_reg <= {(AW+1){1'b0}};
      wgray_s2_reg <= {(AW+1){1'b0}};
    end else begin
      rgray_s1_reg <= rgray_reg; // see (R12)
      rgray_s2_reg <= rgray_s1_reg; // see (R1)
      wgray_s1_reg <= wgray_reg; // see (R12)
      wgray_s2_reg <= wgray_s1_reg; // see (R2), see (R7)
    end
  end
endmodule
`default_nettype wire

// file: src/dcffs_top.v
// nine-bit fifo with strapped second-enable/load pin and avalon registers
// assumes pins synchronous to CLK_I and no traffic until the
// first edge after reset release has caught the strap
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "dcffs_defines.vh"
module dcffs_top (
  input wire CLK_I,
  input wire RST_B_I,
  input wire [`DCFFS_WIDTH-1:0] WR_DATA_I,
  input wire WR_EN_N_I,
  input wire SECOND_WRITE_ENABLE_OR_LOAD_I,
  output reg FULL_FLAG_N_O,
  input wire RD_EN_N_I,
  input wire OUT_ENABLE_N_I,
  output reg [`DCFFS_WIDTH-1:0] RD_DATA_O,
  output reg RD_DATA_OE_N_O,
  output reg RD_VALID_O,
  output reg EMPTY_FLAG_N_O,
  input wire [`DCFFS_ADDR_W-1:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [`DCFFS_DATA_W-1:0] AVS_WRITEDATA_I,
  input wire [3:0] AVS_BYTEENABLE_I,
  output reg [`DCFFS_DATA_W-1:0] AVS_READDATA_O,
  output reg AVS_WAITREQUEST_O
);
  reg cfg_pending_reg;
  reg two_enable_mode_reg;
  reg [`DCFFS_CTRL_W-1:0] ctrl_reg;
  reg [`DCFFS_OFS_SEL_W-1:0] load_wr_sel_reg;
  reg [`DCFFS_OFS_SEL_W-1:0] load_rd_sel_reg;
  reg [`DCFFS_DATA_W-1:0] rdata_next;
  wire [`DCFFS_OFS_W-1:0] offset_val [0:`DCFFS_OFS_COUNT-1];
  wire load_active;
  wire wr_strobe;
  wire rd_strobe;
  wire fifo_wr_req;
  wire fifo_rd_req;
  wire load_wr;
  wire load_rd;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`DCFFS_WIDTH-1:0] fifo_out_data;
  wire fifo_full;
  wire fifo_empty;
  wire bus_req;
  wire bus_ack;
  wire [`DCFFS_OFS_SEL_W-1:0] load_wr_sel_next;
  wire [`DCFFS_OFS_SEL_W-1:0] load_rd_sel_next;

  // strap capture: the pin is read at the first edge after release,
  // since an async-reset flop may only load a constant
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cfg_pending_reg <= 1'b1; // see (R3)
      two_enable_mode_reg <= 1'b1;
    end else if (cfg_pending_reg) begin
      cfg_pending_reg <= 1'b0;
      two_enable_mode_reg <= SECOND_WRITE_ENABLE_OR_LOAD_I; // see (R5)
    end
  end

  // load mode and pin low: offset register access instead of fifo
  assign load_active = ~two_enable_mode_reg &
    ~SECOND_WRITE_ENABLE_OR_LOAD_I; // see (R6)
  // no traffic before the strap is caught
  assign wr_strobe = ~cfg_pending_reg & ~WR_EN_N_I &
    ~ctrl_reg[`DCFFS_CTRL_WINH]; // see (R11)
  assign rd_strobe = ~cfg_pending_reg & ~RD_EN_N_I &
    ~ctrl_reg[`DCFFS_CTRL_RINH];
  // pin high is both the second enable and the "not loading" level
  assign fifo_wr_req = wr_strobe & SECOND_WRITE_ENABLE_OR_LOAD_I; // see (R5)
  assign load_wr = wr_strobe & load_active; // see (R6)
  // reads follow the pin flag, so no word leaves before empty clears
  assign fifo_rd_req = rd_strobe & ~load_active & EMPTY_FLAG_N_O; // see (R8)
  assign load_rd = rd_strobe & load_active; // see (R6)

  dcffs_fifo #(
    .WIDTH(`DCFFS_WIDTH),
    .DEPTH(`DCFFS_DEPTH),
    .AW(`DCFFS_AW)
  ) u_fifo (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .in_valid_i(fifo_wr_req),
    .in_ready_o(fifo_in_ready),
    .in_data_i(WR_DATA_I),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_rd_req),
    .out_data_o(fifo_out_data),
    .full_o(fifo_full),
    .empty_o(fifo_empty)
  );

  // flags are flops off the synced comparisons; the writer sees full,
  // the reader sees empty, each from its own pointer crossing
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      FULL_FLAG_N_O <= 1'b1;
      EMPTY_FLAG_N_O <= 1'b0; // see (R11)
    end else begin
      FULL_FLAG_N_O <= fifo_in_ready; // see (R10), see (R1)
      EMPTY_FLAG_N_O <= fifo_out_valid; // see (R9), see (R2), see (R7)
    end
  end

  // offset load sequence wraps after the fourth register
  assign load_wr_sel_next = load_wr_sel_reg + {{(`DCFFS_OFS_SEL_W-1){1'b0}},
    1'b1};
  assign load_rd_sel_next = load_rd_sel_reg + {{(`DCFFS_OFS_SEL_W-1){1'b0}},
    1'b1};

  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      load_wr_sel_reg <= `DCFFS_SEL_RST;
      load_rd_sel_reg <= `DCFFS_SEL_RST;
    end else begin
      if (load_wr) begin
        load_wr_sel_reg <= load_wr_sel_next; // see (R6)
      end
      if (load_rd) begin
        load_rd_sel_reg <= load_rd_sel_next;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `DCFFS_OFS_COUNT; gi = gi + 1) begin : g_ofs
      reg [`DCFFS_OFS_W-1:0] ofs_reg;
      always @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
          ofs_reg <= `DCFFS_OFS_RST;
        end else if (load_wr && (load_wr_sel_reg == gi)) begin
          ofs_reg <= WR_DATA_I[`DCFFS_OFS_W-1:0]; // see (R6)
        end
      end
      assign offset_val[gi] = ofs_reg;
    end
  endgenerate

  // read port: last word is held when empty, so underflow is harmless
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RD_DATA_O <= {`DCFFS_WIDTH{1'b0}}; // see (R4)
      RD_VALID_O <= 1'b0;
      RD_DATA_OE_N_O <= 1'b1;
    end else begin
      RD_DATA_OE_N_O <= OUT_ENABLE_N_I; // see (R4)
      if (fifo_rd_req && fifo_out_valid) begin
        RD_DATA_O <= fifo_out_data; // see (R8)
        RD_VALID_O <= 1'b1;
      end else if (load_rd) begin
        RD_DATA_O <= {1'b0, offset_val[load_rd_sel_reg]};
        RD_VALID_O <= 1'b1;
      end else begin
        RD_VALID_O <= 1'b0;
      end
    end
  end

  // avalon slave: one wait cycle per request, effect at the ack edge
  assign bus_req = AVS_READ_I | AVS_WRITE_I;
  assign bus_ack = bus_req & ~AVS_WAITREQUEST_O;

  always @* begin
    rdata_next = {`DCFFS_DATA_W{1'b0}};
    if (AVS_ADDRESS_I == `DCFFS_CTRL_ADDR) begin
      rdata_next[`DCFFS_CTRL_W-1:0] = ctrl_reg;
    end else if (AVS_ADDRESS_I == `DCFFS_STATUS_ADDR) begin
      rdata_next[`DCFFS_ST_EMPTY_N] = EMPTY_FLAG_N_O;
      rdata_next[`DCFFS_ST_FULL_N] = FULL_FLAG_N_O;
      rdata_next[`DCFFS_ST_TWO_EN] = two_enable_mode_reg;
      rdata_next[`DCFFS_ST_PENDING] = cfg_pending_reg;
    end else if (AVS_ADDRESS_I == `DCFFS_OFFSET_ADDR) begin
      rdata_next = {offset_val[3], offset_val[2], offset_val[1],
        offset_val[0]};
    end
  end

  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= {`DCFFS_DATA_W{1'b0}};
      ctrl_reg <= `DCFFS_CTRL_RST;
    end else begin
      if (bus_req && AVS_WAITREQUEST_O) begin
        AVS_WAITREQUEST_O <= 1'b0;
        AVS_READDATA_O <= rdata_next;
      end else begin
        AVS_WAITREQUEST_O <= 1'b1;
      end
      // unmapped writes are dropped, unmapped reads return zero
      if (bus_ack && AVS_WRITE_I && AVS_BYTEENABLE_I[0] &&
          (AVS_ADDRESS_I == `DCFFS_CTRL_ADDR)) begin
        ctrl_reg <= AVS_WRITEDATA_I[`DCFFS_CTRL_W-1:0];
      end
    end
  end
endmodule
`default_nettype wire
